// ===== src/mem_port_master.sv
/*
  Bus master for one port of a tagged split-transaction memory hub: queues user requests,
  issues them with a held strobe, keeps issued tags, answers data-phase calls.
  Assumes the hub is logic on the same clock, so its outputs are read without synchronisers.
*/
// How it works
// - address driven in bus word units
// - write enable high write, low read
// - strobe and fields held until acknowledge
// - ack before strobe means accepted on rise
// - read lines ignored after write call
// - write data driven cycle after call
// - mask bit low writes that byte
// - idle write data and mask zero
// - burst length equals I/O over bus rate
// - word width is burst times pins
`timescale 1ns/1ps
`default_nettype none

module mem_port_master #(
  parameter int NUM_TAGS = mem_port_pkg::NUM_TAGS,
  parameter int FIFO_DEPTH = mem_port_pkg::FIFO_DEPTH,
  parameter int TAG_W = $clog2(NUM_TAGS)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire mem_port_pkg::req_t req_i,
  output logic rd_valid_o,
  output logic [mem_port_pkg::ADR_W-1:0] rd_adr_o,
  output logic [mem_port_pkg::DATA_W-1:0] rd_data_o,
  output logic wr_done_o,
  output logic stb_o,
  output logic [mem_port_pkg::ADR_W-1:0] adr_o,
  output logic we_o,
  input wire logic ack_i,
  input wire logic [TAG_W-1:0] tag_issue_i,
  input wire logic call_i,
  input wire logic [TAG_W-1:0] tag_call_i,
  input wire logic [mem_port_pkg::DATA_W-1:0] data_r_i,
  output logic [mem_port_pkg::DATA_W-1:0] data_w_o,
  output logic [mem_port_pkg::MASK_W-1:0] write_byte_mask_o
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ISSUE = 1'b1
  } issue_state_t;

  issue_state_t state_reg;
  issue_state_t state_next;

  // queued requests; the fifo's ready is the user's back-pressure
  logic fifo_valid;
  logic fifo_ready;
  logic [mem_port_pkg::REQ_W-1:0] fifo_data;
  mem_port_pkg::req_t head;
  logic in_ready;

  req_fifo #(
    .WIDTH(mem_port_pkg::REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) req_fifo_inst (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(in_ready),
    .in_data_i(req_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );

  assign head = mem_port_pkg::req_t'(fifo_data);

  // request currently on the strobe
  logic stb_reg;
  logic we_reg;
  logic [mem_port_pkg::ADR_W-1:0] adr_reg;
  logic [mem_port_pkg::DATA_W-1:0] cur_wdata_reg;
  logic [mem_port_pkg::MASK_W-1:0] cur_be_reg;

  // one entry per tag; a call for a tag with no valid entry, such as another master's, is ignored
  logic slot_valid_reg [NUM_TAGS];
  logic slot_we_reg [NUM_TAGS];
  logic [mem_port_pkg::ADR_W-1:0] slot_adr_reg [NUM_TAGS];
  logic [mem_port_pkg::DATA_W-1:0] slot_wdata_reg [NUM_TAGS];
  logic [mem_port_pkg::MASK_W-1:0] slot_be_reg [NUM_TAGS];

  // ack may already stand high when the strobe rises; that cycle is the acceptance
  wire accept = stb_reg && ack_i;
  wire call_hit = call_i && slot_valid_reg[tag_call_i];
  wire write_call = call_hit && slot_we_reg[tag_call_i];
  wire read_call = call_hit && !slot_we_reg[tag_call_i];
  wire [mem_port_pkg::DATA_W-1:0] hit_wdata = slot_wdata_reg[tag_call_i];
  wire [mem_port_pkg::MASK_W-1:0] hit_be = slot_be_reg[tag_call_i];
  wire [mem_port_pkg::ADR_W-1:0] hit_adr = slot_adr_reg[tag_call_i];
  wire load_next = fifo_valid && (state_reg == ST_IDLE || accept);

  assign fifo_ready = load_next;
  assign req_ready_o = in_ready;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (fifo_valid) state_next = ST_ISSUE;
      end
      ST_ISSUE: begin
        if (accept && !fifo_valid) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      stb_reg <= 1'b0;
      we_reg <= 1'b0;
      adr_reg <= '0;
      cur_wdata_reg <= '0;
      cur_be_reg <= '0;
    end else begin
      state_reg <= state_next;
      // strobe and fields change only on acceptance or from idle
      if (load_next) begin
        stb_reg <= 1'b1;
        we_reg <= head.we;
        adr_reg <= head.adr;
        cur_wdata_reg <= head.wdata;
        cur_be_reg <= head.byte_en;
      end else if (accept) begin
        stb_reg <= 1'b0;
      end
    end
  end

  // a tag freed by a call may be issued again in that same cycle, so set wins
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_TAGS; i++) begin
      if (reset_i) begin
        slot_valid_reg[i] <= 1'b0;
        slot_we_reg[i] <= 1'b0;
        slot_adr_reg[i] <= '0;
        slot_wdata_reg[i] <= '0;
        slot_be_reg[i] <= '0;
      end else begin
        if (call_hit && tag_call_i == TAG_W'(i)) slot_valid_reg[i] <= 1'b0;
        if (accept && tag_issue_i == TAG_W'(i)) begin
          slot_valid_reg[i] <= 1'b1;
          slot_we_reg[i] <= we_reg;
          slot_adr_reg[i] <= adr_reg;
          slot_wdata_reg[i] <= cur_wdata_reg;
          slot_be_reg[i] <= cur_be_reg;
        end
      end
    end
  end

  // data phase
  logic [mem_port_pkg::DATA_W-1:0] data_w_reg;
  logic [mem_port_pkg::MASK_W-1:0] mask_reg;
  logic wr_done_reg;
  logic rd_pend_reg;
  logic [mem_port_pkg::ADR_W-1:0] rd_pend_adr_reg;
  logic rd_valid_reg;
  logic [mem_port_pkg::ADR_W-1:0] rd_adr_reg;
  logic [mem_port_pkg::DATA_W-1:0] rd_data_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_w_reg <= '0;
      mask_reg <= '0;
      wr_done_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_pend_adr_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_adr_reg <= '0;
      rd_data_reg <= '0;
    end else begin
      // zero when idle so the controller can OR all masters together
      data_w_reg <= write_call ? hit_wdata : '0;
      mask_reg <= write_call ? ~hit_be : '0;
      wr_done_reg <= write_call;
      // read lines are only sampled after a read call, never after a write call
      rd_pend_reg <= read_call;
      rd_pend_adr_reg <= hit_adr;
      rd_valid_reg <= rd_pend_reg;
      if (rd_pend_reg) begin
        rd_data_reg <= data_r_i;
        rd_adr_reg <= rd_pend_adr_reg;
      end
    end
  end

  assign stb_o = stb_reg;
  assign we_o = we_reg;
  assign adr_o = adr_reg;
  assign data_w_o = data_w_reg;
  assign write_byte_mask_o = mask_reg;
  assign wr_done_o = wr_done_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rd_adr_o = rd_adr_reg;
  assign rd_data_o = rd_data_reg;

  a_stb_hold_fields: assert property (@(posedge clk_i) disable iff (reset_i)
    stb_o && !ack_i |=> stb_o && $stable(adr_o) && $stable(we_o))
    else $error("strobe or request fields changed before acknowledge");

  a_accept_on_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(stb_o) && ack_i |=> slot_valid_reg[$past(tag_issue_i)])
    else $error("request with ack already high not recorded");

  a_slot_direction: assert property (@(posedge clk_i) disable iff (reset_i)
    accept |=> slot_we_reg[$past(tag_issue_i)] == $past(we_o))
    else $error("stored direction differs from issued request");

  a_wdata_after_call: assert property (@(posedge clk_i) disable iff (reset_i)
    write_call |=> data_w_o == $past(hit_wdata) && wr_done_o)
    else $error("write data not driven the cycle after its call");

  a_mask_low_writes: assert property (@(posedge clk_i) disable iff (reset_i)
    write_call |=> write_byte_mask_o == ~$past(hit_be))
    else $error("write mask is not the inverse of the byte enables");

  a_idle_lines_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(write_call) |-> data_w_o == '0 && write_byte_mask_o == '0)
    else $error("write data or mask not zero while idle");

  a_write_no_read: assert property (@(posedge clk_i) disable iff (reset_i)
    write_call |-> ##2 !rd_valid_o)
    else $error("read data taken after a write call");

  a_read_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    read_call ##1 1'b1 |=> rd_valid_o && rd_data_o == $past(data_r_i))
    else $error("read data not returned two cycles after its call");

endmodule

`default_nettype wire

// ===== pkg/mem_port_pkg.sv
/*
  Shared constants and carrier types for the tagged split-transaction memory port master.
  Assumes the hub port runs on the same 200 MHz clock as the master logic.
*/
package mem_port_pkg;

  // bus clock and memory rates set the burst length and word width
  localparam int BUS_MHZ = 200;
  localparam int MEM_CLK_MHZ = 400;
  localparam int DDR_FACTOR = 2;
  localparam int IO_MHZ = MEM_CLK_MHZ * DDR_FACTOR;
  localparam int BURST_LEN = IO_MHZ / BUS_MHZ;
  localparam int DQ_PINS = 16;
  localparam int DATA_W = BURST_LEN * DQ_PINS;
  localparam int MASK_W = DATA_W / 8;
  localparam int ADR_W = 24;
  localparam int NUM_TAGS = 4;
  localparam int FIFO_DEPTH = 8;

  // user request: word address, direction, write data, byte enables (high = write byte)
  typedef struct packed {
    logic we;
    logic [ADR_W-1:0] adr;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] byte_en;
  } req_t;

  localparam int REQ_W = $bits(req_t);

endpackage

// ===== src/req_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and registered ready and empty flags.
  Assumes one synchronous active-high reset; depth of at least two.
*/
`timescale 1ns/1ps
`default_nettype none

module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic ready_reg;
  logic empty_reg;

  wire push = in_valid_i && ready_reg;
  wire pop = out_ready_i && !empty_reg;
  wire [CNT_W-1:0] count_next = (push && !pop) ? count_reg + 1'b1 :
                                (pop && !push) ? count_reg - 1'b1 : count_reg;

  // ready is kept as its own flop so the port reaches the user with no logic after it
  assign in_ready_o = ready_reg;
  assign out_valid_o = !empty_reg;
  assign out_data_o = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= next_ptr(wr_ptr_reg);
      if (pop) rd_ptr_reg <= next_ptr(rd_ptr_reg);
      count_reg <= count_next;
      ready_reg <= (count_next != FULL_CNT);
      empty_reg <= (count_next == '0);
    end
  end

  a_fifo_count_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    count_reg <= FULL_CNT && (ready_reg == (count_reg != FULL_CNT)))
    else $error("fifo count out of range or ready flag wrong");

endmodule

`default_nettype wire

// ===== verif/hub_model.sv
/*
  Behavioural hub port: three tag slots for this master, small word memory, calls held slots.
  Assumes a master on the same clock; tag 3 belongs to another master; addresses below 64.
*/
`timescale 1ns/1ps
`default_nettype none
module hub_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic call_en_i,
  input wire logic foreign_i,
  input wire logic stb_i,
  input wire logic [23:0] adr_i,
  input wire logic we_i,
  output logic ack_o,
  output logic [1:0] tag_issue_o,
  output logic call_o,
  output logic [1:0] tag_call_o,
  output logic [63:0] data_r_o,
  input wire logic [63:0] data_w_i,
  input wire logic [7:0] mask_i
);
  logic [63:0] mem [64];
  logic [2:0] busy_reg, clr, set, free, cand;
  logic sw [4];
  logic [23:0] sa [4];
  logic wr_pend;
  logic [23:0] pa;
  initial foreach (mem[i]) mem[i] = 64'h0;
  assign clr = call_o ? 3'h1 << tag_call_o : 3'h0;
  assign set = (stb_i && ack_o) ? 3'h1 << tag_issue_o : 3'h0;
  assign free = ~busy_reg | clr;
  assign tag_issue_o = free[0] ? 2'h0 : free[1] ? 2'h1 : 2'h2;
  // ack does not wait for stb, so a rising stb is taken at once
  assign ack_o = !slow_i && |free;
  assign cand = busy_reg & ~clr;
  always @(posedge clk_i) begin
    if (reset_i) begin
      busy_reg <= 3'h0;
      call_o <= 1'b0;
      wr_pend <= 1'b0;
      data_r_o <= 64'h5a5a_5a5a_5a5a_5a5a;
    end else begin
      busy_reg <= (busy_reg & ~clr) | set;
      if (stb_i && ack_o) begin
        sw[tag_issue_o] <= we_i;
        sa[tag_issue_o] <= adr_i;
      end
      call_o <= foreign_i || (call_en_i && |cand);
      tag_call_o <= foreign_i ? 2'h3 : cand[0] ? 2'h0 : cand[1] ? 2'h1 : 2'h2;
      wr_pend <= |clr && sw[tag_call_o];
      pa <= sa[tag_call_o];
      // read lines toggle when not valid so a stray sample is caught
      data_r_o <= (|clr && !sw[tag_call_o]) ? mem[sa[tag_call_o][5:0]] : ~data_r_o;
      if (wr_pend) begin
        for (int b = 0; b < 8; b++) begin
          if (!mask_i[b]) mem[pa[5:0]][8*b+:8] <= data_w_i[8*b+:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/split_txn_memory_hub_port_tb.sv
/*
  Self-checking bench for the memory port master against the behavioural hub.
  Assumes hub_model; word addresses stay below 64.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module split_txn_memory_hub_port_tb;
  logic clk_i = 0, reset_i = 1, req_valid_i = 0, slow = 0, call_en = 1, foreign = 0;
  mem_port_pkg::req_t req_i = '0;
  logic req_ready_o, rd_valid_o, wr_done_o, stb_o, we_o, ack_i, call_i;
  logic [23:0] rd_adr_o, adr_o;
  logic [63:0] rd_data_o, data_r_i, data_w_o;
  logic [7:0] write_byte_mask_o;
  logic [1:0] tag_issue_i, tag_call_i;
  logic pstb = 0, pack = 0, pwe = 0;
  logic [23:0] padr = 0;
  logic [63:0] exp [64];
  int n_fail = 0, total_checks = 0, gr = 0, gw = 0;
  always #2.5 clk_i = ~clk_i;
  mem_port_master mem_port_master_inst (.clk_i, .reset_i, .req_valid_i, .req_ready_o, .req_i, .rd_valid_o,
    .rd_adr_o, .rd_data_o, .wr_done_o, .stb_o, .adr_o, .we_o, .ack_i, .tag_issue_i, .call_i, .tag_call_i,
    .data_r_i, .data_w_o, .write_byte_mask_o);
  hub_model hub_model_inst (.clk_i, .reset_i, .slow_i(slow), .call_en_i(call_en), .foreign_i(foreign),
    .stb_i(stb_o), .adr_i(adr_o), .we_i(we_o), .ack_o(ack_i), .tag_issue_o(tag_issue_i), .call_o(call_i),
    .tag_call_o(tag_call_i), .data_r_o(data_r_i), .data_w_i(data_w_o), .mask_i(write_byte_mask_o));
  always @(negedge clk_i) begin
    if (!reset_i) begin
      if (!wr_done_o) `CHK({data_w_o, write_byte_mask_o}, 72'h0, "idle write lines")
      if (pstb && !pack) `CHK({stb_o, we_o, adr_o}, {1'b1, pwe, padr}, "request changed")
      // results are counted here so a call that lands while a task is still pushing is not lost
      if (rd_valid_o === 1'b1) begin
        `CHK(rd_data_o, exp[rd_adr_o[5:0]], "read data")
        gr++;
      end
      if (wr_done_o === 1'b1) gw++;
      pstb = stb_o;
      pack = ack_i;
      pwe = we_o;
      padr = adr_o;
    end
  end
  task automatic push(logic we, logic [23:0] a, logic [63:0] d, logic [7:0] be);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{we, a, d, be};
    repeat (200) begin
      @(posedge clk_i);
      if (req_ready_o) break;
    end
    `CHK(req_ready_o, 1'b1, "request not taken")
    req_valid_i <= 1'b0;
    // expected memory merges the enabled bytes only
    for (int b = 0; b < 8; b++) if (we && be[b]) exp[a[5:0]][8*b+:8] = d[8*b+:8];
  endtask
  task automatic collect(int nr, int nw);
    repeat (300) @(posedge clk_i);
    `CHK(gr, nr, "read count")
    `CHK(gw, nw, "write count")
    gr = 0;
    gw = 0;
  endtask
  task automatic t_basic;
    push(1'b1, 24'h5, 64'h1122_3344_5566_7788, 8'hff);
    collect(0, 1);
    push(1'b1, 24'h5, 64'hffff_ffff_ffff_ffff, 8'h0f);
    push(1'b1, 24'h6, 64'h0123_4567_89ab_cdef, 8'ha5);
    push(1'b0, 24'h5, 64'h0, 8'h0);
    collect(1, 2);
    $display("test basic done");
  endtask
  task automatic t_stall;
    slow <= 1'b1;
    push(1'b0, 24'h6, 64'h0, 8'h0);
    repeat (6) @(posedge clk_i);
    slow <= 1'b0;
    collect(1, 0);
    $display("test stall done");
  endtask
  task automatic t_fill;
    slow <= 1'b1;
    for (int i = 0; i < 9; i++) push(1'b1, 24'h10 + i, {8{i[7:0]}}, 8'hff);
    @(posedge clk_i);
    #1;
    `CHK(req_ready_o, 1'b0, "fifo not full")
    slow <= 1'b0;
    collect(0, 9);
    call_en <= 1'b0;
    for (int i = 0; i < 9; i++) push(1'b0, 24'h10 + i, 64'h0, 8'h0);
    call_en <= 1'b1;
    collect(9, 0);
    $display("test fill done");
  endtask
  task automatic t_foreign;
    call_en <= 1'b0;
    push(1'b0, 24'h11, 64'h0, 8'h0);
    foreign <= 1'b1;
    @(posedge clk_i);
    foreign <= 1'b0;
    collect(0, 0);
    call_en <= 1'b1;
    collect(1, 0);
    $display("test foreign done");
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    foreach (exp[i]) exp[i] = 64'h0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    t_basic();
    t_stall();
    t_fill();
    t_foreign();
    summarize();
  end
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
